// [logic/fmd_pkg.sv]
// Constants, types and helpers for the fault monitor and trouble-code reporter.
// Assumes one 125 MHz clock and an APB master with 32-bit data.
// What this block does
// - Trouble code packs SPN, FMI, zero, count
// - Previous-codes list sent only on request
// - Blocks 1-3 default: supply, temperature, timeouts
// - Four selectable fault types per block
// - Min/max: two thresholds, quiet between them
// - Absolute: one threshold, quiet below it
// - State: fixed thresholds one and zero
// - Double min/max: four independently configured thresholds
// - Current-feedback faults keep per-output error flag
// - Supply/temperature flags disable outputs when enabled
// - No-fault message; announce when last clears
// - Newly active code sends message immediately
// - Several active codes use multipacket transfer
// - No active-fault broadcast for five seconds
// - Delay qualifies fault, then activate and count
// - Vanished fault becomes previously active
// - Clear-on-request codes stay until clear request
// - Lamp byte from per-event lamp selection
// - Zero parameter number sends no message
// - Changing parameter number zeroes occurrence count
// - Failure mode accepts 0-21 and 31
// - High and low modes never paired automatically
// - Flagging delay counted in milliseconds
package fmd_pkg;
    localparam int NBLK = 4;
    localparam int NSLOT = 4;
    localparam int NEV = NBLK * NSLOT;
    localparam int NSRC = 8;
    localparam int NOUT = 4;
    localparam int CLK_HZ = 125_000_000;
    localparam int TICK_MS = 1;
    localparam int MS_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
    localparam int HOLDOFF_S = 5;
    localparam int HOLDOFF_MS_DEF = HOLDOFF_S * 1000;
    localparam int PERIOD_S = 1;
    localparam logic [15:0] PERIOD_MS = 16'(PERIOD_S * 1000);
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STAT = 12'h004;
    localparam logic [7:0] ADDR_BLK_HI = 8'h01;
    localparam logic [3:0] ADDR_EV_HI = 4'h1;
    localparam logic [1:0] EV_CFG = 2'h0;
    localparam logic [1:0] EV_THR = 2'h1;
    localparam logic [1:0] EV_SPN = 2'h2;
    localparam logic [1:0] EV_DTC = 2'h3;
    localparam int CFG_GEN = 0;
    localparam int CFG_CLR = 1;
    localparam int CFG_LAMP = 2;
    localparam int CFG_FMI = 4;
    localparam int CFG_DLY = 16;
    localparam int CTRL_PWR = 0;
    localparam int CTRL_TMP = 1;
    localparam logic [2:0] SRC_SUPPLY = 3'h0;
    localparam logic [2:0] SRC_TEMP = 3'h1;
    localparam logic [2:0] SRC_RXTO = 3'h2;
    localparam logic [2:0] SRC_OUT0 = 3'h3;
    localparam logic [1:0] DEF_LAMP = 2'h1;
    localparam logic [15:0] DEF_DELAY = 16'h03e8;
    localparam logic [15:0] DEF_THR = 16'h0000;
    localparam logic [6:0] OC_MAX = 7'h7f;
    localparam logic [4:0] FMI_TOP = 5'h15;
    localparam logic [4:0] FMI_EXIST = 5'h1f;

    typedef enum logic [1:0] {MODE_MINMAX, MODE_ABS, MODE_STATE, MODE_DOUBLE} fmd_mode_e;
    typedef enum logic [1:0] {MSG_DM1_NONE, MSG_DM1_SINGLE, MSG_DM1_MULTI, MSG_DM2} fmd_kind_e;

    typedef struct packed {
        logic      valid;
        fmd_kind_e kind;
        logic [7:0] lamp;
        logic [4:0] count;
        logic [31:0] dtc;
    } fmd_msg_s;

    function automatic logic [31:0] fmd_dtc(input logic [18:0] spn, input logic [4:0] fmi,
                                            input logic [6:0] oc);
        fmd_dtc = {spn[7:0], spn[15:8], spn[18:16], fmi, 1'b0, oc};
    endfunction

    function automatic logic fmd_fmi_ok(input logic [4:0] fmi);
        fmd_fmi_ok = (fmi <= FMI_TOP) || (fmi == FMI_EXIST);
    endfunction

    // Min/max: slot 0 low side, slot 1 high side; double: even slots low side, odd slots high side; absolute and state use slot 0 for the high side.
    function automatic logic fmd_cond(input fmd_mode_e mode, input int slot,
                                      input logic [15:0] v, input logic [15:0] thr);
        fmd_cond = 1'b0;
        case (mode)
            MODE_MINMAX: fmd_cond = (slot == 0) ? (v < thr) : (slot == 1) ? (v > thr) : 1'b0;
            MODE_ABS:    fmd_cond = (slot == 0) && (v >= thr);
            MODE_STATE:  fmd_cond = (slot == 0) && (v >= 16'h0001);
            MODE_DOUBLE: fmd_cond = slot[0] ? (v > thr) : (v < thr);
            default:     fmd_cond = 1'b0;
        endcase
    endfunction

    function automatic logic [2:0] fmd_def_src(input int blk);
        fmd_def_src = (blk == 0) ? SRC_SUPPLY : (blk == 1) ? SRC_TEMP : SRC_RXTO;
    endfunction

    function automatic logic [7:0] fmd_lamp_bits(input logic [1:0] sel);
        fmd_lamp_bits = 8'h01 << {sel, 1'b0};
    endfunction
endpackage

// [logic/fmd_monitor.sv]
// Fault monitor: threshold checks, flagging delay, trouble codes and message scheduling.
// Assumes synchronous inputs, APB register access and a CAN layer that frames the messages.
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module fmd_monitor #(
    parameter int MS_CYCLES  = fmd_pkg::MS_CYCLES_DEF,
    parameter int HOLDOFF_MS = fmd_pkg::HOLDOFF_MS_DEF
) (
    input  wire logic                 clk_in,
    input  wire logic                 srst_in,
    input  wire logic                 psel_in,
    input  wire logic                 penable_in,
    input  wire logic                 pwrite_in,
    input  wire logic [11:0]          paddr_in,
    input  wire logic [31:0]          pwdata_in,
    output logic      [31:0]          prdata_out,
    output logic                      pready_out,
    output logic                      pslverr_out,
    input  wire logic [7:0][15:0]     monitor_value_in,
    input  wire logic                 dm2_request_in,
    input  wire logic                 dm11_request_in,
    output fmd_pkg::fmd_msg_s         msg_out,
    output logic [fmd_pkg::NOUT-1:0]  out_fault_out,
    output logic                      outputs_disable_out
);
    import fmd_pkg::*;

    logic [15:0] thr [NEV];
    logic [18:0] spn [NEV];
    logic [4:0]  fmi [NEV];
    logic [1:0]  lamp [NEV];
    logic [15:0] dly [NEV];
    logic [15:0] elapsed [NEV];
    logic [6:0]  oc [NEV];
    logic [NEV-1:0] gen_en, clr_req, flag, active, prev, cond, qual, spn_chg;
    fmd_mode_e   mode [NBLK];
    logic [2:0]  src [NBLK];
    logic [1:0]  ctrl;
    logic [31:0] ms_cnt;
    logic        ms_tick;
    logic [15:0] hold_cnt, per_cnt;
    logic        hold_done, dm2_pend;
    logic [NEV-1:0] qual_q;

    // APB decode: two-cycle access, pready comes from a flop.
    wire         acc      = psel_in && penable_in;
    wire         wr       = acc && pready_out && pwrite_in;
    wire         is_ev    = (paddr_in[11:8] == ADDR_EV_HI) && (paddr_in[1:0] == 2'h0);
    wire         is_blk   = (paddr_in[11:4] == ADDR_BLK_HI)
                            && ({1'b0, paddr_in[3:2]} < 3'(NBLK))
                            && (paddr_in[1:0] == 2'h0);
    wire         is_ctrl  = (paddr_in == ADDR_CTRL);
    wire         is_stat  = (paddr_in == ADDR_STAT);
    wire         mapped   = is_ev || is_blk || is_ctrl || is_stat;
    wire [3:0]   ev_i     = paddr_in[7:4];
    wire [1:0]   reg_i    = paddr_in[3:2];
    wire [1:0]   blk_i    = paddr_in[3:2];
    wire [4:0]   wr_fmi   = pwdata_in[CFG_FMI +: 5];
    wire [31:0]  ev_cfg   = {dly[ev_i], 7'h00, fmi[ev_i], lamp[ev_i], clr_req[ev_i], gen_en[ev_i]};
    wire [31:0]  ev_word  = (reg_i == EV_CFG) ? ev_cfg :
                            (reg_i == EV_THR) ? {16'h0000, thr[ev_i]} :
                            (reg_i == EV_SPN) ? {13'h0000, spn[ev_i]} :
                            fmd_dtc(spn[ev_i], fmi[ev_i], oc[ev_i]);
    wire [4:0]   n_active = 5'($countones(qual));
    wire [31:0]  stat_w   = {prev, 3'h0, hold_done, 7'h00, n_active};
    wire [31:0]  rd_word  = is_ev ? ev_word :
                            is_blk ? {27'h0, src[blk_i], mode[blk_i]} :
                            is_ctrl ? {30'h0, ctrl} :
                            is_stat ? stat_w : 32'h0000_0000;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pready_out  <= 1'b0;
            prdata_out  <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end else begin
            pready_out  <= acc && !pready_out;
            prdata_out  <= (acc && !pready_out && !pwrite_in) ? rd_word : 32'h0000_0000;
            pslverr_out <= acc && !pready_out && !mapped;
        end
    end

    // Configuration. Illegal failure-mode codes are ignored and the old value stays.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ctrl <= 2'h0;
            for (int b = 0; b < NBLK; b++) begin
                mode[b] <= MODE_MINMAX;
                src[b]  <= fmd_def_src(b);
            end
            for (int e = 0; e < NEV; e++) begin
                thr[e]     <= DEF_THR;
                spn[e]     <= 19'h00000;
                fmi[e]     <= e[0] ? 5'h00 : 5'h01;
                lamp[e]    <= DEF_LAMP;
                dly[e]     <= DEF_DELAY;
                gen_en[e]  <= 1'b1;
                clr_req[e] <= 1'b0;
            end
        end else if (wr) begin
            if (is_ctrl) ctrl <= pwdata_in[1:0];
            if (is_blk) begin
                mode[blk_i] <= fmd_mode_e'(pwdata_in[1:0]);
                src[blk_i]  <= pwdata_in[4:2];
            end
            if (is_ev && reg_i == EV_CFG) begin
                gen_en[ev_i]  <= pwdata_in[CFG_GEN];
                clr_req[ev_i] <= pwdata_in[CFG_CLR];
                lamp[ev_i]    <= pwdata_in[CFG_LAMP +: 2];
                dly[ev_i]     <= pwdata_in[CFG_DLY +: 16];
                if (fmd_fmi_ok(wr_fmi)) fmi[ev_i] <= wr_fmi;
            end
            if (is_ev && reg_i == EV_THR) thr[ev_i] <= pwdata_in[15:0];
            if (is_ev && reg_i == EV_SPN) spn[ev_i] <= pwdata_in[18:0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NEV; g++) begin : g_ev
            // Each slot has its own threshold and its own code parameters.
            assign cond[g] = fmd_cond(mode[g / NSLOT], g % NSLOT,
                                      monitor_value_in[src[g / NSLOT]], thr[g]);
            assign spn_chg[g] = wr && is_ev && (reg_i == EV_SPN) && (ev_i == 4'(g))
                                && (pwdata_in[18:0] != spn[g]);
            assign qual[g] = active[g] && gen_en[g] && (spn[g] != 19'h00000);
        end
    endgenerate

    // Millisecond time base shared by all delay timers.
    always_ff @(posedge clk_in) begin
        if (srst_in || ms_tick) ms_cnt <= 32'h0000_0000;
        else ms_cnt <= ms_cnt + 32'h0000_0001;
        if (srst_in) ms_tick <= 1'b0;
        else ms_tick <= (ms_cnt == 32'(MS_CYCLES - 2));
    end

    // Fault qualification and code state per event.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            flag   <= '0;
            active <= '0;
            prev   <= '0;
            for (int e = 0; e < NEV; e++) begin
                elapsed[e] <= 16'h0000;
                oc[e]      <= 7'h00;
            end
        end else begin
            for (int e = 0; e < NEV; e++) begin
                if (!cond[e]) begin
                    elapsed[e] <= 16'h0000;
                    flag[e]    <= 1'b0;
                    if (flag[e] && !clr_req[e]) begin
                        active[e] <= 1'b0;
                        prev[e]   <= 1'b1;
                    end
                end else if (!flag[e] && elapsed[e] >= dly[e]) begin
                    flag[e]   <= 1'b1;
                    active[e] <= 1'b1;
                    prev[e]   <= 1'b0;
                    if (gen_en[e] && spn[e] != 19'h00000 && oc[e] != OC_MAX)
                        oc[e] <= oc[e] + 7'h01;
                end else if (!flag[e] && ms_tick) begin
                    elapsed[e] <= elapsed[e] + 16'h0001;
                end
                // A clear request drops only codes whose cause has already gone.
                if (dm11_request_in && active[e] && !flag[e]) begin
                    active[e] <= 1'b0;
                    prev[e]   <= 1'b1;
                end
                if (spn_chg[e]) oc[e] <= 7'h00;
            end
        end
    end

    // Internal flags for outputs, supply and temperature.
    logic [NBLK-1:0] blk_flag;
    logic [NOUT-1:0] next_out_fault;
    logic            sup_err, tmp_err;
    always_comb begin
        next_out_fault = '0;
        sup_err = 1'b0;
        tmp_err = 1'b0;
        for (int b = 0; b < NBLK; b++) begin
            blk_flag[b] = |flag[b * NSLOT +: NSLOT];
            sup_err = sup_err || (blk_flag[b] && src[b] == SRC_SUPPLY);
            tmp_err = tmp_err || (blk_flag[b] && src[b] == SRC_TEMP);
            for (int o = 0; o < NOUT; o++)
                if (blk_flag[b] && src[b] == SRC_OUT0 + 3'(o)) next_out_fault[o] = 1'b1;
        end
    end

    wire next_disable = (sup_err && ctrl[CTRL_PWR]) || (tmp_err && ctrl[CTRL_TMP]);

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            out_fault_out       <= '0;
            outputs_disable_out <= 1'b0;
        end else begin
            out_fault_out       <= next_out_fault;
            outputs_disable_out <= next_disable;
        end
    end

    // Message scheduling.
    logic [31:0] first_dtc;
    logic [7:0]  lamp_byte;
    logic [4:0]  n_prev;
    always_comb begin
        first_dtc = 32'h0000_0000;
        lamp_byte = 8'h00;
        n_prev    = 5'h00;
        for (int e = NEV - 1; e >= 0; e--) begin
            if (qual[e]) first_dtc = fmd_dtc(spn[e], fmi[e], oc[e]);
            if (qual[e]) lamp_byte = lamp_byte | fmd_lamp_bits(lamp[e]);
            if (prev[e] && spn[e] != 19'h00000) n_prev = n_prev + 5'h01;
        end
    end

    wire new_act   = |(qual & ~qual_q);
    wire went_none = (qual_q != '0) && (qual == '0);
    wire per_due   = ms_tick && (per_cnt == PERIOD_MS - 16'h0001);
    wire send_dm1  = hold_done && (new_act || went_none || per_due);
    wire [1:0] kind_sel = (n_active == 5'h00) ? 2'h0 : (n_active == 5'h01) ? 2'h1 : 2'h2;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            hold_cnt  <= 16'h0000;
            hold_done <= 1'b0;
            per_cnt   <= 16'h0000;
            qual_q    <= '0;
            dm2_pend  <= 1'b0;
            msg_out   <= '0;
        end else begin
            qual_q <= qual;
            if (ms_tick && !hold_done) hold_cnt <= hold_cnt + 16'h0001;
            if (hold_cnt == 16'(HOLDOFF_MS)) hold_done <= 1'b1;
            if (send_dm1) per_cnt <= 16'h0000;
            else if (ms_tick) per_cnt <= per_due ? 16'h0000 : per_cnt + 16'h0001;
            msg_out.valid <= send_dm1 || dm2_pend;
            if (send_dm1) begin
                msg_out.kind  <= fmd_kind_e'(kind_sel);
                msg_out.lamp  <= lamp_byte;
                msg_out.count <= n_active;
                msg_out.dtc   <= first_dtc;
            end else if (dm2_pend) begin
                msg_out.kind  <= MSG_DM2;
                msg_out.lamp  <= 8'h00;
                msg_out.count <= n_prev;
                msg_out.dtc   <= 32'h0000_0000;
            end
            // A request arriving while the pending one goes out is kept.
            if (dm2_request_in) dm2_pend <= 1'b1;
            else if (!send_dm1) dm2_pend <= 1'b0;
        end
    end

    sequence s_new_fault;
        new_act && hold_done;
    endsequence
    chk_new_fault_msg: assert property (@(posedge clk_in) disable iff (srst_in)
        s_new_fault |=> msg_out.valid && msg_out.kind != MSG_DM2)
        else $error("New active code produced no message.");
    chk_holdoff_quiet: assert property (@(posedge clk_in) disable iff (srst_in)
        msg_out.valid && msg_out.kind != MSG_DM2 |-> $past(hold_done))
        else $error("Fault message sent during start-up holdoff.");
    chk_dm2_request: assert property (@(posedge clk_in) disable iff (srst_in)
        msg_out.valid && msg_out.kind == MSG_DM2 |-> $past(dm2_pend))
        else $error("Previous-code list sent without request.");
    chk_multi_kind: assert property (@(posedge clk_in) disable iff (srst_in)
        msg_out.valid && msg_out.count > 5'h01 && msg_out.kind != MSG_DM2
        |-> msg_out.kind == MSG_DM1_MULTI)
        else $error("Several codes not sent as multipacket.");
    chk_cm_zero: assert property (@(posedge clk_in) disable iff (srst_in)
        msg_out.valid |-> msg_out.dtc[7] == 1'b0)
        else $error("Conversion method bit not zero.");
    chk_disable_out: assert property (@(posedge clk_in) disable iff (srst_in)
        sup_err && ctrl[CTRL_PWR] |=> outputs_disable_out)
        else $error("Supply fault did not disable outputs.");
    chk_spn_oc: assert property (@(posedge clk_in) disable iff (srst_in)
        spn_chg[0] |=> oc[0] == 7'h00)
        else $error("Occurrence count kept after parameter number change.");
    chk_spn_zero: assert property (@(posedge clk_in) disable iff (srst_in)
        spn[0] == 19'h00000 |-> !qual[0])
        else $error("Code with zero parameter number reported.");
    chk_fmi_legal: assert property (@(posedge clk_in) disable iff (srst_in)
        fmd_fmi_ok(fmi[0]) && fmd_fmi_ok(fmi[1]))
        else $error("Illegal failure mode stored.");
    chk_default_src: assert property (@(posedge clk_in)
        $past(srst_in) |-> src[0] == SRC_SUPPLY && src[1] == SRC_TEMP && src[2] == SRC_RXTO)
        else $error("Default monitored sources wrong after reset.");
    chk_clear_keep: assert property (@(posedge clk_in) disable iff (srst_in)
        flag[0] && !cond[0] && clr_req[0] && !dm11_request_in |=> active[0])
        else $error("Clear-on-request code dropped without request.");
endmodule
`default_nettype wire

// [tb/fmd_peer.sv]
// Far-side node model: other units on the network that ask for codes.
// Assumes the reporter's message struct and one shared clock.
`timescale 1ns/100ps
`default_nettype none
module fmd_peer (
    input  wire logic        clk_in,
    input  wire fmd_pkg::fmd_msg_s msg_in,
    output logic             dm2_request_out,
    output logic             dm11_request_out
);
    import fmd_pkg::*;
    int rx_count = 0;

    initial begin
        dm2_request_out = 1'b0;
        dm11_request_out = 1'b0;
    end

    always @(posedge clk_in) begin
        if (msg_in.valid === 1'b1) begin
            rx_count <= rx_count + 1;
        end
    end

    // A request is a single-cycle pulse, as a received frame would be.
    task automatic ask_previous();
        @(posedge clk_in) dm2_request_out <= 1'b1;
        @(posedge clk_in) dm2_request_out <= 1'b0;
    endtask

    task automatic ask_clear();
        @(posedge clk_in) dm11_request_out <= 1'b1;
        @(posedge clk_in) dm11_request_out <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [tb/fault_monitor_dtc_reporter_tb.sv]
// Self-checking bench for the fault monitor with a node model on the far side.
// Assumes shortened ms tick (4 cycles) and holdoff (3 ticks) parameters.
`timescale 1ns/100ps
`default_nettype none
module fault_monitor_dtc_reporter_tb;
    import fmd_pkg::*;
    logic             clk_in = 1'b0;
    logic             srst_in = 1'b1;
    logic             psel = 1'b0;
    logic             penable = 1'b0;
    logic             pwrite = 1'b0;
    logic [11:0]      paddr = 12'h000;
    logic [31:0]      pwdata = 32'h0;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic [7:0][15:0] mon;
    logic             dm2_req;
    logic             dm11_req;
    fmd_msg_s         msg_out;
    logic [NOUT-1:0]  out_fault;
    logic             out_dis;
    logic [31:0]      rdata;
    logic             rerr;
    logic [18:0]      spn0;
    logic [4:0]       fmi0;
    fmd_msg_s         m;
    int               t;
    int               n_mismatch = 0;
    int               n_checks = 0;

    always #4 clk_in = ~clk_in;

    fmd_monitor #(.MS_CYCLES(4), .HOLDOFF_MS(3)) i_dut (
        .clk_in(clk_in), .srst_in(srst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .monitor_value_in(mon),
        .dm2_request_in(dm2_req), .dm11_request_in(dm11_req), .msg_out(msg_out),
        .out_fault_out(out_fault), .outputs_disable_out(out_dis));

    fmd_peer i_peer (.clk_in(clk_in), .msg_in(msg_out), .dm2_request_out(dm2_req),
        .dm11_request_out(dm11_req));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", pready, 1'b1);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, rdata, exp);
    endtask

    // Waits for the next message; periodic no-fault frames can be skipped.
    task automatic wait_msg(input bit skip_none);
        t = 0;
        m = '0;
        while (t < 200) begin
            @(posedge clk_in);
            t++;
            if (msg_out.valid === 1'b1 && !(skip_none && msg_out.kind == MSG_DM1_NONE)) begin
                m = msg_out;
                break;
            end
        end
        chk("msg_seen", 32'(t < 200), 32'h1);
    endtask

    function automatic logic [31:0] exp_dtc(input logic [18:0] s, input logic [4:0] f,
                                            input int oc);
        return {s[7:0], s[15:8], s[18:16], f, 1'b0, 7'(oc)};
    endfunction

    function automatic logic [31:0] cfg(input bit g, input bit c, input logic [1:0] l,
                                        input logic [4:0] f, input logic [15:0] d);
        return {d, 7'h00, f, l, c, g};
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_in);
        n_mismatch++;
        summarize();
    end

    initial begin
        void'($urandom(35));
        mon = '0;
        mon[0] = 16'h00c8;
        repeat (16) @(posedge clk_in);
        srst_in <= 1'b0;
        repeat (12) begin
            @(posedge clk_in);
            chk("early_valid", msg_out.valid, 1'b0);
        end
        rd_chk(ADDR_STAT, 32'h0000_1000, "status");
        rd_chk(12'h010, 32'h0, "blk0");
        rd_chk(12'h014, 32'h4, "blk1");
        rd_chk(12'h018, 32'h8, "blk2");
        rd_chk(12'h100, cfg(1, 0, 1, 1, 16'h03e8), "cfg0");
        rd_chk(12'h0f0, 32'h0, "unmapped");
        chk("slverr", rerr, 1'b1);
        spn0 = 19'($urandom_range(1, 19'h7ffff));
        fmi0 = 5'($urandom_range(0, 21));
        apb(1'b1, 12'h114, 32'h0000_ffff);
        apb(1'b1, 12'h108, 32'(spn0));
        apb(1'b1, 12'h104, 32'h0000_0064);
        apb(1'b1, 12'h100, cfg(1, 0, 2, fmi0, 16'h0002));
        mon[0] <= 16'h0032;
        wait_msg(1);
        chk("delay_ok", 32'(t >= 8 && t <= 14), 32'h1);
        chk("kind1", m.kind, MSG_DM1_SINGLE);
        chk("lamp1", m.lamp, 8'h10);
        chk("dtc1", m.dtc, exp_dtc(spn0, fmi0, 1));
        apb(1'b1, 12'h01c, 32'h0000_000d);
        apb(1'b1, 12'h1c8, 32'h0000_1234);
        apb(1'b1, 12'h1c4, 32'h0000_000a);
        apb(1'b1, 12'h1c0, cfg(1, 0, 1, 5, 16'h0000));
        mon[3] <= 16'h0014;
        wait_msg(1);
        chk("kind2", m.kind, MSG_DM1_MULTI);
        chk("count2", m.count, 5'h02);
        chk("dtc2", m.dtc, exp_dtc(spn0, fmi0, 1));
        chk("out_fault", out_fault, 4'h1);
        apb(1'b1, ADDR_CTRL, 32'h1);
        repeat (2) @(posedge clk_in);
        chk("disable_on", out_dis, 1'b1);
        apb(1'b1, ADDR_CTRL, 32'h0);
        repeat (2) @(posedge clk_in);
        chk("disable_off", out_dis, 1'b0);
        mon[3] <= 16'h0000;
        repeat (12) @(posedge clk_in);
        mon[0] <= 16'h00c8;
        wait_msg(0);
        chk("kind_none", m.kind, MSG_DM1_NONE);
        rd_chk(ADDR_STAT, 32'h1001_1000, "status_prev");
        i_peer.ask_previous();
        wait_msg(1);
        chk("kind_dm2", m.kind, MSG_DM2);
        chk("count_dm2", m.count, 5'h02);
        apb(1'b1, 12'h100, cfg(1, 1, 2, 5'(22 + $urandom_range(0, 8)), 16'h0000));
        rd_chk(12'h100, cfg(1, 1, 2, fmi0, 16'h0000), "fmi_kept");
        mon[0] <= 16'h0032;
        wait_msg(1);
        chk("dtc3", m.dtc, exp_dtc(spn0, fmi0, 2));
        mon[0] <= 16'h00c8;
        repeat (20) @(posedge clk_in);
        rd_chk(ADDR_STAT, 32'h1000_1001, "held_active");
        i_peer.ask_clear();
        wait_msg(0);
        chk("kind_clear", m.kind, MSG_DM1_NONE);
        apb(1'b1, 12'h018, 32'h0000_000a);
        apb(1'b1, 12'h188, 32'h0000_0777);
        apb(1'b1, 12'h180, cfg(1, 0, 1, 9, 16'h0000));
        mon[2] <= 16'h0001;
        wait_msg(1);
        chk("kind_state", m.kind, MSG_DM1_SINGLE);
        chk("dtc_state", m.dtc, exp_dtc(19'h00777, 5'h09, 1));
        mon[2] <= 16'h0000;
        wait_msg(0);
        chk("state_none", m.kind, MSG_DM1_NONE);
        chk("peer_rx", 32'(i_peer.rx_count > 0), 32'h1);
        spn0 = spn0 ^ 19'h00001;
        apb(1'b1, 12'h108, 32'(spn0));
        rd_chk(12'h10c, exp_dtc(spn0, fmi0, 0), "dtc_reset");
        summarize();
    end
endmodule
`default_nettype wire
